// *** src/acdg_top.v ***
// Purpose : Converter calibration registers, power-up load and DMA port gating
// Assumes : APB slave, single clock, DMA engine and core on the same clock
// Notes   : Core port drives are replaced by DMA drives while DMA mode is set
// Functional notes
// [RL1] In DMA mode core drives never reach external ports zero and two.
// [RL2] Core keeps running during DMA; only its port accesses are suppressed.
// [RL3] Interrupt output raised on DMA completion when software enabled it.
// [RL4] Offset and gain coefficients are 14-bit values in registers.
// [RL5] Offset coefficient split into six-bit high and eight-bit low registers.
// [RL6] Gain coefficient split into six-bit high and eight-bit low registers.
// [RL7] Larger offset coefficient shifts transfer down; smaller shifts it up.
// [RL8] Full offset span corrects about five percent of reference either way.
// [RL9] Larger gain coefficient raises slope; smaller lowers it.
// [RL10] Gain range covers input spans 0.975 to 1.025 of reference.
// [RL11] Factory coefficients copied from hidden area at power-up before code runs.
// [RL12] Control register two bit 6 enters DMA mode.
// [RL13] DMA completion sets the conversion done flag in hardware.
// [RL14] Software can read and overwrite all four coefficient registers.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "acdg_defines.vh"

module acdg_top (
    input  wire        CLK,
    input  wire        RST_N,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire [7:0]  CORE_P0_OUT,
    input  wire        CORE_P0_OE,
    input  wire [7:0]  CORE_P2_OUT,
    input  wire        CORE_P2_OE,
    output reg  [7:0]  CORE_P0_IN,
    input  wire [7:0]  DMA_P0_OUT,
    input  wire        DMA_P0_OE,
    input  wire [7:0]  DMA_P2_OUT,
    input  wire        DMA_P2_OE,
    output reg  [7:0]  DMA_P0_IN,
    input  wire        DMA_DONE,
    input  wire [7:0]  P0_IN,
    output reg  [7:0]  P0_OUT,
    output reg         P0_OE,
    output reg  [7:0]  P2_OUT,
    output reg         P2_OE,
    input  wire        RAW_VALID,
    input  wire [11:0] RAW_CODE,
    output wire        CAL_VALID,
    output wire [11:0] CAL_CODE,
    output reg         CORE_RUN,
    output reg         DMA_MODE,
    output reg         CORE_IRQ
);

    // ****************************************************************
    // Load sequencer states
    // ****************************************************************
    localparam ST_FETCH = 2'h0;
    localparam ST_STORE = 2'h1;
    localparam ST_DONE  = 2'h2;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [5:0]  offset_coef_high;
    reg  [7:0]  offset_coef_low;
    reg  [5:0]  gain_coef_high;
    reg  [7:0]  gain_coef_low;
    reg  [7:0]  adc_control_two;
    reg         conversion_done_flag;
    reg         irq_enable;
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [2:0]  load_idx;
    reg  [2:0]  next_load_idx;
    reg         load_done;
    reg  [7:0]  p0_meta;
    reg  [7:0]  p0_sync;
    reg  [31:0] next_rdata;
    reg         next_err;
    wire [7:0]  nv_data;
    wire        setup_phase;
    wire        wr_commit;
    wire        dma_active;
    wire        addr_hit;
    wire [13:0] ofs_coef;
    wire [13:0] gain_coef;

    assign setup_phase = PSEL & ~PREADY;
    assign wr_commit   = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
    assign dma_active  = adc_control_two[`ACDG_CTRL_DMA_BIT];                  // RL12
    assign ofs_coef    = {offset_coef_high, offset_coef_low};                  // RL4 RL5
    assign gain_coef   = {gain_coef_high, gain_coef_low};                      // RL4 RL6

    // ****************************************************************
    // Hidden coefficient area
    // ****************************************************************
    acdg_nv_rom u_nv_rom (
        .clk   (CLK),
        .addr  (load_idx[1:0]),
        .rdata (nv_data)
    );

    // ****************************************************************
    // Power-up load sequencer
    // ****************************************************************
    always @* begin
        next_state    = state;
        next_load_idx = load_idx;
        case (state)
            ST_FETCH: begin
                next_state = ST_STORE;
            end
            ST_STORE: begin
                next_load_idx = load_idx + 3'h1;
                if (load_idx == `ACDG_NV_WORDS - 3'h1)
                    next_state = ST_DONE;
                else
                    next_state = ST_FETCH;
            end
            ST_DONE: begin
                next_state = ST_DONE;
            end
            default: begin
                next_state    = ST_FETCH;
                next_load_idx = 3'h0;
            end
        endcase
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            state     <= ST_FETCH;
            load_idx  <= 3'h0;
            load_done <= 1'b0;
            CORE_RUN  <= 1'b0;
        end else begin
            state     <= next_state;
            load_idx  <= next_load_idx;
            load_done <= (next_state == ST_DONE);                              // RL11
            CORE_RUN  <= (next_state == ST_DONE);                              // RL11 RL2
        end
    end

    // ****************************************************************
    // Coefficient registers
    // ****************************************************************
    always @(posedge CLK) begin
        if (!RST_N) begin
            offset_coef_high <= `ACDG_COEF_HIGH_RST;
            offset_coef_low  <= `ACDG_COEF_LOW_RST;
            gain_coef_high   <= `ACDG_COEF_HIGH_RST;
            gain_coef_low    <= `ACDG_COEF_LOW_RST;
        end else if (state == ST_STORE) begin
            case (load_idx[1:0])                                               // RL11
                2'h0:    offset_coef_high <= nv_data[5:0];
                2'h1:    offset_coef_low  <= nv_data;
                2'h2:    gain_coef_high   <= nv_data[5:0];
                default: gain_coef_low    <= nv_data;
            endcase
        end else if (wr_commit) begin
            case (PADDR)                                                       // RL14
                `ACDG_ADDR_OFS_HIGH:  offset_coef_high <= PWDATA[5:0];         // RL5
                `ACDG_ADDR_OFS_LOW:   offset_coef_low  <= PWDATA[7:0];         // RL5
                `ACDG_ADDR_GAIN_HIGH: gain_coef_high   <= PWDATA[5:0];         // RL6
                `ACDG_ADDR_GAIN_LOW:  gain_coef_low    <= PWDATA[7:0];         // RL6
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Control, flag and interrupt enable
    // ****************************************************************
    always @(posedge CLK) begin
        if (!RST_N) begin
            adc_control_two <= `ACDG_CTRL_TWO_RST;
            irq_enable      <= 1'b0;
        end else if (wr_commit) begin
            if (PADDR == `ACDG_ADDR_CTRL_TWO)
                adc_control_two <= PWDATA[7:0];                                // RL12
            if (PADDR == `ACDG_ADDR_IRQ_EN)
                irq_enable <= PWDATA[`ACDG_IRQ_EN_BIT];                        // RL3
        end
    end

    // Completion in DMA mode sets the flag; set wins over a write-one clear
    always @(posedge CLK) begin
        if (!RST_N) begin
            conversion_done_flag <= 1'b0;
        end else if (DMA_DONE && dma_active) begin
            conversion_done_flag <= 1'b1;                                      // RL13
        end else if (wr_commit && PADDR == `ACDG_ADDR_STATUS &&
                     PWDATA[`ACDG_STAT_DONE_BIT]) begin
            conversion_done_flag <= 1'b0;
        end
    end

    always @(posedge CLK) begin
        if (!RST_N)
            CORE_IRQ <= 1'b0;
        else
            CORE_IRQ <= irq_enable &
                        (conversion_done_flag | (DMA_DONE & dma_active));      // RL3
    end

    // ****************************************************************
    // APB read and response
    // ****************************************************************
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (PADDR)
            `ACDG_ADDR_OFS_HIGH:  next_rdata[5:0] = offset_coef_high;          // RL14
            `ACDG_ADDR_OFS_LOW:   next_rdata[7:0] = offset_coef_low;           // RL14
            `ACDG_ADDR_GAIN_HIGH: next_rdata[5:0] = gain_coef_high;            // RL14
            `ACDG_ADDR_GAIN_LOW:  next_rdata[7:0] = gain_coef_low;             // RL14
            `ACDG_ADDR_CTRL_TWO:  next_rdata[7:0] = adc_control_two;
            `ACDG_ADDR_STATUS: begin
                next_rdata[`ACDG_STAT_DONE_BIT] = conversion_done_flag;
                next_rdata[`ACDG_STAT_LOAD_BIT] = load_done;
                next_rdata[`ACDG_STAT_DMA_BIT]  = dma_active;
            end
            `ACDG_ADDR_IRQ_EN:    next_rdata[`ACDG_IRQ_EN_BIT] = irq_enable;
            default:              next_err = 1'b1;
        endcase
        if (!PWRITE && PADDR == `ACDG_ADDR_STATUS)
            next_err = 1'b0;
    end

    // Answers only after the power-up load has finished
    always @(posedge CLK) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else if (setup_phase && load_done) begin                           // RL11
            PREADY  <= 1'b1;
            PSLVERR <= next_err;
            PRDATA  <= PWRITE ? 32'h0000_0000 : next_rdata;
        end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Port input synchroniser
    // ****************************************************************
    always @(posedge CLK) begin
        if (!RST_N) begin
            p0_meta <= 8'h00;
            p0_sync <= 8'h00;
        end else begin
            p0_meta <= P0_IN;
            p0_sync <= p0_meta;
        end
    end

    // ****************************************************************
    // External port ownership
    // ****************************************************************
    always @(posedge CLK) begin
        if (!RST_N) begin
            P0_OUT     <= 8'h00;
            P0_OE      <= 1'b0;
            P2_OUT     <= 8'h00;
            P2_OE      <= 1'b0;
            CORE_P0_IN <= 8'h00;
            DMA_P0_IN  <= 8'h00;
            DMA_MODE   <= 1'b0;
        end else begin
            DMA_MODE <= dma_active;
            if (dma_active) begin
                P0_OUT     <= DMA_P0_OUT;                                      // RL1
                P0_OE      <= DMA_P0_OE;                                       // RL1
                P2_OUT     <= DMA_P2_OUT;                                      // RL1
                P2_OE      <= DMA_P2_OE;                                       // RL1
                CORE_P0_IN <= 8'h00;                                           // RL2
                DMA_P0_IN  <= p0_sync;
            end else begin
                P0_OUT     <= CORE_P0_OUT;
                P0_OE      <= CORE_P0_OE;
                P2_OUT     <= CORE_P2_OUT;
                P2_OE      <= CORE_P2_OE;
                CORE_P0_IN <= p0_sync;
                DMA_P0_IN  <= 8'h00;
            end
        end
    end

    // ****************************************************************
    // Conversion correction
    // ****************************************************************
    acdg_cal_path u_cal_path (
        .clk       (CLK),
        .rst_n     (RST_N),
        .ofs_coef  (ofs_coef),                                                 // RL7 RL8
        .gain_coef (gain_coef),                                                // RL9 RL10
        .raw_valid (RAW_VALID),
        .raw_code  (RAW_CODE),
        .cal_valid (CAL_VALID),
        .cal_code  (CAL_CODE)
    );

endmodule

// *** src/acdg_defines.vh ***
// Purpose : Shared constants for the converter calibration and DMA gating block
// Assumes : APB byte addresses, 32-bit data, one word per register
// Notes   : Included by bare name from every design file
`ifndef ACDG_DEFINES_VH
`define ACDG_DEFINES_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ACDG_ADDR_OFS_HIGH   12'h000
`define ACDG_ADDR_OFS_LOW    12'h004
`define ACDG_ADDR_GAIN_HIGH  12'h008
`define ACDG_ADDR_GAIN_LOW   12'h00c
`define ACDG_ADDR_CTRL_TWO   12'h010
`define ACDG_ADDR_STATUS     12'h014
`define ACDG_ADDR_IRQ_EN     12'h018

// ****************************************************************
// Field positions
// ****************************************************************
`define ACDG_CTRL_DMA_BIT    6
`define ACDG_STAT_DONE_BIT   0
`define ACDG_STAT_LOAD_BIT   1
`define ACDG_STAT_DMA_BIT    2
`define ACDG_IRQ_EN_BIT      0

// ****************************************************************
// Reset values
// ****************************************************************
`define ACDG_COEF_HIGH_RST   6'h20
`define ACDG_COEF_LOW_RST    8'h00
`define ACDG_CTRL_TWO_RST    8'h00

// ****************************************************************
// Factory coefficients in the hidden area (arbitrary values)
// ****************************************************************
`define ACDG_NV_OFS_HIGH     8'h20
`define ACDG_NV_OFS_LOW      8'h00
`define ACDG_NV_GAIN_HIGH    8'h20
`define ACDG_NV_GAIN_LOW     8'h00

// ****************************************************************
// Correction arithmetic
// ****************************************************************
`define ACDG_COEF_MID        15'sh2000
`define ACDG_OFS_SCALE       9'sh0cd
`define ACDG_OFS_SHIFT       13
`define ACDG_GAIN_SCALE      7'sh33
`define ACDG_GAIN_SHIFT      24
`define ACDG_CODE_MAX        12'hfff

// ****************************************************************
// Power-up load sequence
// ****************************************************************
`define ACDG_NV_WORDS        3'h4

`endif

// *** src/acdg_nv_rom.v ***
// Purpose : Hidden nonvolatile area holding factory coefficients
// Assumes : Four bytes, read data registered
// Notes   : Word order offset high, offset low, gain high, gain low
`timescale 1ns/1ps
`include "acdg_defines.vh"

module acdg_nv_rom (
    input  wire       clk,
    input  wire [1:0] addr,
    output reg  [7:0] rdata
);

    // ****************************************************************
    // Registered read
    // ****************************************************************
    always @(posedge clk) begin
        case (addr)
            2'h0:    rdata <= `ACDG_NV_OFS_HIGH;
            2'h1:    rdata <= `ACDG_NV_OFS_LOW;
            2'h2:    rdata <= `ACDG_NV_GAIN_HIGH;
            default: rdata <= `ACDG_NV_GAIN_LOW;
        endcase
    end

endmodule

// *** src/acdg_cal_path.v ***
// Purpose : Offset and gain correction of raw conversion codes
// Assumes : 12-bit codes, 14-bit coefficients centred on 2000h
// Notes   : One cycle latency, result clamped to code range
`timescale 1ns/1ps
`include "acdg_defines.vh"

module acdg_cal_path (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [13:0] ofs_coef,
    input  wire [13:0] gain_coef,
    input  wire        raw_valid,
    input  wire [11:0] raw_code,
    output reg         cal_valid,
    output reg  [11:0] cal_code
);

    // ****************************************************************
    // Offset shift
    // ****************************************************************
    wire signed [14:0] ofs_dev  = $signed({1'b0, ofs_coef}) - `ACDG_COEF_MID;
    wire signed [23:0] ofs_prod = ofs_dev * `ACDG_OFS_SCALE;
    wire signed [23:0] ofs_shr  = ofs_prod >>> `ACDG_OFS_SHIFT;
    wire signed [13:0] ofs_step = ofs_shr[13:0];
    wire signed [13:0] x_ofs    = $signed({2'b00, raw_code}) - ofs_step;

    // ****************************************************************
    // Gain scaling
    // ****************************************************************
    wire signed [14:0] gain_dev  = $signed({1'b0, gain_coef}) - `ACDG_COEF_MID;
    wire signed [35:0] gain_prod = x_ofs * gain_dev * `ACDG_GAIN_SCALE;
    wire signed [35:0] gain_shr  = gain_prod >>> `ACDG_GAIN_SHIFT;
    wire signed [14:0] y_full    = {x_ofs[13], x_ofs} + gain_shr[14:0];

    always @(posedge clk) begin
        if (!rst_n) begin
            cal_valid <= 1'b0;
            cal_code  <= 12'h000;
        end else begin
            cal_valid <= raw_valid;
            if (raw_valid) begin
                if (y_full[14])
                    cal_code <= 12'h000;
                else if (y_full[13:12] != 2'b00)
                    cal_code <= `ACDG_CODE_MAX;
                else
                    cal_code <= y_full[11:0];
            end
        end
    end

endmodule

// *** test/acdg_top_chk.sv ***
// Purpose : Concurrent checks on the calibration and port gating block
// Assumes : Single clock, synchronous active-low reset
// Notes   : Bound to the top module below
`timescale 1ns/1ps
`include "acdg_defines.vh"

module acdg_top_chk (
    input wire        CLK,
    input wire        RST_N,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [11:0] PADDR,
    input wire        PREADY,
    input wire [7:0]  CORE_P0_OUT,
    input wire        CORE_P0_OE,
    input wire        DMA_P0_OE,
    input wire        DMA_P2_OE,
    input wire        P0_OE,
    input wire [7:0]  P0_OUT,
    input wire        P2_OE,
    input wire        DMA_DONE,
    input wire        RAW_VALID,
    input wire        CAL_VALID,
    input wire        CORE_RUN,
    input wire        DMA_MODE,
    input wire        CORE_IRQ
);
    // ************************************************************
    // Edges since reset release
    // ************************************************************
    reg [3:0] up_cnt;
    always @(posedge CLK) begin
        if (!RST_N)
            up_cnt <= 4'h0;
        else if (up_cnt != 4'hf)
            up_cnt <= up_cnt + 4'h1;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // ************************************************************
    // Assertions
    // ************************************************************
    chk_p0_gated: assert property ($past(RST_N) && DMA_MODE |-> P0_OE == $past(DMA_P0_OE))
        else $error("port zero driven by core in dma mode");
    chk_p2_gated: assert property ($past(RST_N) && DMA_MODE |-> P2_OE == $past(DMA_P2_OE))
        else $error("port two driven by core in dma mode");
    chk_core_drive: assert property ($past(RST_N) && !DMA_MODE && $past(CORE_P0_OE)
        |-> P0_OE && P0_OUT == $past(CORE_P0_OUT)) else $error("core drive lost outside dma mode");
    chk_load_time: assert property (CORE_RUN == (up_cnt >= 4'h8))
        else $error("coefficient load length wrong");
    chk_ready_wait: assert property (!CORE_RUN |-> !PREADY)
        else $error("bus answered before load done");
    chk_apb_answer: assert property (PSEL && !PENABLE && CORE_RUN |=> PREADY ##1 !PREADY)
        else $error("bus answer timing wrong");
    chk_irq_cause: assert property ($rose(CORE_IRQ) && !$past(PSEL, 2) |-> $past(DMA_DONE && DMA_MODE))
        else $error("interrupt without dma completion");
    chk_cal_latency: assert property ($past(RST_N) |-> CAL_VALID == $past(RAW_VALID))
        else $error("corrected code latency wrong");
    chk_mode_source: assert property ($changed(DMA_MODE) |-> $past(PSEL && PENABLE && PWRITE && PREADY
        && PADDR == `ACDG_ADDR_CTRL_TWO, 2)) else $error("dma mode changed without control write");

    cov_dma_done: cover property (DMA_MODE && DMA_DONE);
    cov_irq: cover property ($rose(CORE_IRQ));
    cov_gated: cover property (DMA_MODE && CORE_P0_OE);
endmodule

bind acdg_top acdg_top_chk chk (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PREADY(PREADY), .CORE_P0_OUT(CORE_P0_OUT), .CORE_P0_OE(CORE_P0_OE),
    .DMA_P0_OE(DMA_P0_OE), .DMA_P2_OE(DMA_P2_OE), .P0_OE(P0_OE), .P0_OUT(P0_OUT), .P2_OE(P2_OE),
    .DMA_DONE(DMA_DONE), .RAW_VALID(RAW_VALID), .CAL_VALID(CAL_VALID), .CORE_RUN(CORE_RUN),
    .DMA_MODE(DMA_MODE), .CORE_IRQ(CORE_IRQ));

// *** test/acdg_dma_model.sv ***
// Purpose : Far-side dma engine writing a short block to external memory
// Assumes : Same clock as the block
// Notes   : Released port lines show the inverse of the next sequence value
`timescale 1ns/1ps

module acdg_dma_model (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       go,
    output wire [7:0] p0_out,
    output wire       p0_oe,
    output wire [7:0] p2_out,
    output wire       p2_oe,
    output reg        done
);
    reg [2:0] cnt;
    reg [7:0] seq;
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt  <= 3'h0;
            seq  <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= (cnt == 3'h1);
            if (go)
                cnt <= 3'h4;
            else if (cnt != 3'h0)
                cnt <= cnt - 3'h1;
            if (cnt != 3'h0)
                seq <= seq + 8'h13;
        end
    end
    assign p0_oe  = (cnt != 3'h0);
    assign p2_oe  = p0_oe;
    assign p0_out = p0_oe ? seq : ~seq;
    assign p2_out = p0_oe ? {seq[3:0], 4'h0} : ~{seq[3:0], 4'h0};
endmodule

// *** test/tb_adc_calibration_and_dma_gating.sv ***
// Purpose : Self-checking bench for calibration registers and dma gating
// Assumes : Bus answers after the setup cycle once the load is done
// Notes   : Expected codes worked out by hand from the correction formula
`timescale 1ns/1ps
`include "acdg_defines.vh"
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin num_errors++; \
    $display("FAIL %0t %s", $time, msg); end end

module tb_adc_calibration_and_dma_gating;
    reg         CLK, RST_N, PSEL, PENABLE, PWRITE, RAW_VALID, CORE_P0_OE, go;
    reg  [11:0] PADDR, RAW_CODE;
    reg  [31:0] PWDATA;
    reg  [7:0]  CORE_P0_OUT, P0_IN;
    wire [31:0] PRDATA;
    wire [11:0] CAL_CODE;
    wire [7:0]  CORE_P0_IN, DMA_P0_IN, P0_OUT, P2_OUT, DMA_P0_OUT, DMA_P2_OUT;
    wire        PREADY, PSLVERR, P0_OE, P2_OE, CAL_VALID, CORE_RUN, DMA_MODE, CORE_IRQ;
    wire        DMA_P0_OE, DMA_P2_OE, DMA_DONE;
    int         num_errors = 0;
    int         compares = 0;
    reg  [31:0] rd;
    reg         er;

    acdg_top dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CORE_P0_OUT(CORE_P0_OUT),
        .CORE_P0_OE(CORE_P0_OE), .CORE_P2_OUT(~CORE_P0_OUT), .CORE_P2_OE(CORE_P0_OE), .CORE_P0_IN(CORE_P0_IN),
        .DMA_P0_OUT(DMA_P0_OUT), .DMA_P0_OE(DMA_P0_OE), .DMA_P2_OUT(DMA_P2_OUT), .DMA_P2_OE(DMA_P2_OE),
        .DMA_P0_IN(DMA_P0_IN), .DMA_DONE(DMA_DONE), .P0_IN(P0_IN), .P0_OUT(P0_OUT), .P0_OE(P0_OE),
        .P2_OUT(P2_OUT), .P2_OE(P2_OE), .RAW_VALID(RAW_VALID), .RAW_CODE(RAW_CODE), .CAL_VALID(CAL_VALID),
        .CAL_CODE(CAL_CODE), .CORE_RUN(CORE_RUN), .DMA_MODE(DMA_MODE), .CORE_IRQ(CORE_IRQ));
    acdg_dma_model far (.clk(CLK), .rst_n(RST_N), .go(go), .p0_out(DMA_P0_OUT), .p0_oe(DMA_P0_OE),
        .p2_out(DMA_P2_OUT), .p2_oe(DMA_P2_OE), .done(DMA_DONE));

    // ************************************************************
    // Bus and closing tasks
    // ************************************************************
    task apb(input bit wr, input [11:0] a, input [31:0] wd);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= wr; PADDR <= a; PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        n = 0;
        while (PREADY !== 1'b1 && n < 60) begin
            @(posedge CLK);
            n++;
        end
        `CHK(PREADY, 1'b1, "bus answer missing")
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0; PENABLE <= 1'b0;
    endtask

    task final_report;
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_load;
        reg [7:0] exp [4];
        exp = '{`ACDG_NV_OFS_HIGH, `ACDG_NV_OFS_LOW, `ACDG_NV_GAIN_HIGH, `ACDG_NV_GAIN_LOW};
        for (int i = 0; i < 4; i++) begin
            apb(0, 12'(i * 4), 32'h0);
            `CHK(rd, {24'h0, exp[i]}, "factory coefficient not loaded")
        end
        `CHK(CORE_RUN, 1'b1, "core not running after load")
    endtask

    task t_coef_rw;
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'(i * 4), 32'hffffffff);
            apb(0, 12'(i * 4), 32'h0);
            `CHK(rd, (i % 2) ? 32'hff : 32'h3f, "coefficient width wrong")
        end
        apb(0, 12'h01c, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0}, "unmapped read not refused")
    endtask

    task t_cal;
        reg [13:0] ofs [7];
        reg [13:0] gn [7];
        reg [11:0] raw [7];
        reg [11:0] exp [7];
        ofs = '{14'h2000, 14'h3fff, 14'h0000, 14'h2000, 14'h2000, 14'h2000, 14'h3fff};
        gn = '{14'h2000, 14'h2000, 14'h2000, 14'h3fff, 14'h0000, 14'h3fff, 14'h2000};
        raw = '{12'd1000, 12'd1000, 12'd1000, 12'd2000, 12'd2000, 12'd4095, 12'd100};
        exp = '{12'd1000, 12'd796, 12'd1205, 12'd2049, 12'd1950, 12'd4095, 12'd0};
        for (int i = 0; i < 7; i++) begin
            apb(1, `ACDG_ADDR_OFS_HIGH, {26'h0, ofs[i][13:8]});
            apb(1, `ACDG_ADDR_OFS_LOW, {24'h0, ofs[i][7:0]});
            apb(1, `ACDG_ADDR_GAIN_HIGH, {26'h0, gn[i][13:8]});
            apb(1, `ACDG_ADDR_GAIN_LOW, {24'h0, gn[i][7:0]});
            @(posedge CLK);
            RAW_VALID <= 1'b1; RAW_CODE <= raw[i];
            @(posedge CLK);
            RAW_VALID <= 1'b0;
            @(posedge CLK);
            `CHK({CAL_VALID, CAL_CODE}, {1'b1, exp[i]}, "corrected code wrong")
        end
    endtask

    task t_ports;
        @(posedge CLK);
        CORE_P0_OE <= 1'b1; CORE_P0_OUT <= 8'h3c; P0_IN <= 8'ha5;
        repeat (2) @(posedge CLK);
        `CHK({P0_OE, P0_OUT, P2_OE, P2_OUT}, {1'b1, 8'h3c, 1'b1, 8'hc3}, "core drive missing")
        apb(1, `ACDG_ADDR_CTRL_TWO, 32'h40);
        repeat (4) @(posedge CLK);
        `CHK(DMA_MODE, 1'b1, "dma mode not entered")
        `CHK({P0_OE, P2_OE}, 2'b00, "core drive reached ports in dma mode")
        `CHK({CORE_P0_IN, DMA_P0_IN}, {8'h00, 8'ha5}, "pin input routing wrong")
        `CHK(CORE_RUN, 1'b1, "core halted in dma mode")
    endtask

    task t_done;
        int n;
        apb(1, `ACDG_ADDR_IRQ_EN, 32'h1);
        @(posedge CLK);
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        n = 0;
        while (CORE_IRQ !== 1'b1 && n < 20) begin
            @(posedge CLK);
            n++;
        end
        `CHK(CORE_IRQ, 1'b1, "no interrupt on completion")
        apb(0, `ACDG_ADDR_STATUS, 32'h0);
        `CHK(rd, 32'h7, "done flag not set")
        apb(1, `ACDG_ADDR_STATUS, 32'h1);
        apb(1, `ACDG_ADDR_CTRL_TWO, 32'h0);
        @(posedge CLK);
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        repeat (10) @(posedge CLK);
        apb(0, `ACDG_ADDR_STATUS, 32'h0);
        `CHK({CORE_IRQ, CORE_P0_IN, rd}, {1'b0, 8'ha5, 32'h2}, "completion outside dma mode counted")
    endtask

    // ************************************************************
    // Clock, reset, sequence and watchdog
    // ************************************************************
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    initial begin
        RST_N = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 12'h000; PWDATA = 32'h0;
        RAW_VALID = 1'b0; RAW_CODE = 12'h000; CORE_P0_OE = 1'b0; CORE_P0_OUT = 8'h00; P0_IN = 8'h00; go = 1'b0;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        t_load;
        t_coef_rw;
        t_cal;
        t_ports;
        t_done;
        final_report;
    end

    initial begin
        repeat (5000) @(posedge CLK);
        num_errors++;
        final_report;
    end
endmodule
